//--- hw/plk_defines.svh
// Constants for the port lockout and fail policy block.
// Assumes a 32-bit register port with one-cycle read latency.
// Functional notes
// - Isolate clear: packet flow follows output and input enable bits and the fail policy.
// - Isolate set: no packets either way; link-requests still sent and answered.
// - Isolated port answers each received packet with packet-not-accepted.
// - Packet received while isolated sets receive-error and receive-error-stopped flags.
// - Isolate set drops fabric packets and flushes transmit and receive queues.
// - Isolation and flush leave acknowledge ID values unchanged.
// - Port kind bit 31 is read-only and reads 1 for serial.
// - Error block header carries feature ID 0x0007.
// - Hard reset and self-reset clear all; port reset clears port registers.
// - Writable reset values may be replaced at boot by register loading.
// - Powered-down port ignores writes and reads zero.
// - Bus and transport errors go to bit 0 of port error detect.
// - All registers are 32 bits on aligned addresses.
// - General block at 0x1000; ports from 0x1040 by 0x40 to 0x1400.
// - At fail threshold, halt and discard bits choose outbound behaviour.
// - Halt 0 discard 0: keep transmitting regardless.
// - Halt 0 discard 1: drop refused packets while failed, flag, resume on heal.
// - Halt 1 discard 0: stop transmitting once output-failed, port congests.
// - Both set: discard queued packets once output-failed, flag each drop.
// - Both set: only packets queued at that moment are discarded.
// - Halt bit 28 and discard bit 29 are read-write, reset 0.
`ifndef PLK_DEFINES_SVH
`define PLK_DEFINES_SVH
`define PLK_ADDR_W 16
`define PLK_OFF_HDR 16'h1000
`define PLK_OFF_CTL 16'h105C
`define PLK_OFF_STAT 16'h1058
`define PLK_OFF_EDET 16'h1040
`define PLK_OFF_ACK 16'h1048
`define PLK_OFF_PWR 16'h1050
`define PLK_PORT_BASE 16'h1040
`define PLK_PORT_STEP 16'h0040
`define PLK_HDR_VAL 32'h0000_0007
`define PLK_BIT_HALT 28
`define PLK_BIT_DROP 29
`define PLK_BIT_ISO 30
`define PLK_BIT_KIND 31
`define PLK_BIT_OUT_EN 9
`define PLK_BIT_IN_EN 10
`define PLK_CTL_RST 32'h8000_0600
`define PLK_CTL_WMASK 32'h7000_0600
`define PLK_ST_RX_ERR 0
`define PLK_ST_RX_STOP 1
`define PLK_ST_OUT_FAIL 2
`define PLK_ST_OUT_DROP 3
`define PLK_ST_W 4
`endif

//--- hw/plk_pkg.sv
// Types for the port lockout and fail policy block.
// Assumes the defines header is included by users.
package plk_pkg;
  typedef enum logic [1:0] {
    PLK_SEND,
    PLK_DROP_NACK,
    PLK_HALT,
    PLK_PURGE
  } plk_policy_e;
endpackage : plk_pkg

//--- hw/plk_port_ctl.sv
// Lockout and failed-link policy for one serial switch port.
// Assumes link-side events are single-cycle pulses on clk.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "plk_defines.svh"
module plk_port_ctl import plk_pkg::*; #(
  parameter int PORT_ID = 0,
  parameter int CNT_W = 8,
  parameter int QCNT_W = 8
) (
  // Clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic self_rst,
  input wire logic port_rst,
  // Boot loading of writable control fields
  input wire logic boot_load,
  input wire logic [31:0] boot_ctl,
  // Register port
  input wire logic [`PLK_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Power state
  input wire logic port_pwr_down,
  // Error rate
  input wire logic [CNT_W-1:0] error_rate_counter,
  input wire logic [CNT_W-1:0] error_rate_fail_level,
  input wire logic fail_level_en,
  // Receive side from link
  input wire logic rx_pkt,
  input wire logic rx_link_req,
  output logic rx_accept,
  output logic rx_nack,
  output logic link_resp,
  input wire logic tx_link_req_want,
  output logic tx_link_req,
  // Error reports
  input wire logic bus_err,
  input wire logic [5:0] ack_id_in,
  input wire logic ack_id_load,
  // Transmit side from switch_fabric
  input wire logic fab_valid,
  output logic fab_ready,
  output logic fab_drop,
  input wire logic tx_nack,
  input wire logic q_level_dec,
  output logic tx_enable,
  output logic tx_discard,
  output logic q_flush
);
  localparam logic [`PLK_ADDR_W-1:0] PBASE =
    `PLK_ADDR_W'(`PLK_PORT_BASE + PORT_ID * `PLK_PORT_STEP);

  logic [31:0] ctl_q;
  logic [`PLK_ST_W-1:0] stat_q;
  logic edet_q;
  logic [5:0] ack_q;
  logic iso_q;
  logic [QCNT_W-1:0] qcnt_q;
  logic [QCNT_W-1:0] purge_q;
  logic failed;
  logic out_fail;
  logic port_clr;
  logic wr_ok;
  plk_policy_e policy;

  function automatic logic hit(input logic [`PLK_ADDR_W-1:0] a,
                               input logic [`PLK_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  // ------------------------------------------------------------
  // Decode and policy
  // ------------------------------------------------------------
  assign port_clr = rst | self_rst | port_rst;
  assign wr_ok = reg_wr & ~port_pwr_down;
  assign failed = fail_level_en & (error_rate_counter >= error_rate_fail_level);
  assign out_fail = stat_q[`PLK_ST_OUT_FAIL];

  always_comb begin
    unique case ({ctl_q[`PLK_BIT_HALT], ctl_q[`PLK_BIT_DROP]})
      2'b00: policy = PLK_SEND;
      2'b01: policy = PLK_DROP_NACK;
      2'b10: policy = PLK_HALT;
      2'b11: policy = PLK_PURGE;
    endcase
  end

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (port_clr) begin
      ctl_q <= `PLK_CTL_RST;
    end else if (boot_load) begin
      ctl_q <= (boot_ctl & `PLK_CTL_WMASK) | (`PLK_CTL_RST & ~`PLK_CTL_WMASK);
    end else if (wr_ok && hit(reg_addr, PBASE + 16'h001C)) begin
      // Kind bit and reserved bits keep reset value
      ctl_q <= (reg_wdata & `PLK_CTL_WMASK) | (ctl_q & ~`PLK_CTL_WMASK);
    end
  end

  always_ff @(posedge clk) begin
    if (port_clr) begin
      iso_q <= 1'b0;
    end else begin
      iso_q <= ctl_q[`PLK_BIT_ISO];
    end
  end

  // ------------------------------------------------------------
  // Status flags, set wins over write-one-clear
  // ------------------------------------------------------------
  logic [`PLK_ST_W-1:0] st_set;
  logic [`PLK_ST_W-1:0] st_clr;
  always_comb begin
    st_set = '0;
    st_set[`PLK_ST_RX_ERR] = rx_pkt & ctl_q[`PLK_BIT_ISO];
    st_set[`PLK_ST_RX_STOP] = rx_pkt & ctl_q[`PLK_BIT_ISO];
    st_set[`PLK_ST_OUT_FAIL] = failed;
    st_set[`PLK_ST_OUT_DROP] = tx_discard | (fab_drop & ~ctl_q[`PLK_BIT_ISO]);
    st_clr = (wr_ok && hit(reg_addr, PBASE + 16'h0018)) ? reg_wdata[`PLK_ST_W-1:0] : '0;
  end

  always_ff @(posedge clk) begin
    if (port_clr) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~st_clr) | st_set;
    end
  end

  always_ff @(posedge clk) begin
    if (port_clr) begin
      edet_q <= 1'b0;
    end else if (bus_err) begin
      edet_q <= 1'b1;
    end else if (wr_ok && hit(reg_addr, PBASE) && reg_wdata[0]) begin
      edet_q <= 1'b0;
    end
  end

  // Ack IDs follow the link only, never the flush
  always_ff @(posedge clk) begin
    if (port_clr) begin
      ack_q <= '0;
    end else if (ack_id_load) begin
      ack_q <= ack_id_in;
    end
  end

  // ------------------------------------------------------------
  // Queue occupancy and purge snapshot
  // ------------------------------------------------------------
  logic q_in;
  logic q_out;
  assign q_in = fab_valid & fab_ready & ~fab_drop;
  assign q_out = q_level_dec & (qcnt_q != '0);

  always_ff @(posedge clk) begin
    if (port_clr || q_flush) begin
      qcnt_q <= '0;
    end else begin
      qcnt_q <= qcnt_q + QCNT_W'(q_in) - QCNT_W'(q_out);
    end
  end

  // Snapshot taken on failure entry
  always_ff @(posedge clk) begin
    if (port_clr || q_flush) begin
      purge_q <= '0;
    end else if (policy == PLK_PURGE && failed && !out_fail) begin
      purge_q <= qcnt_q;
    end else if (q_out && purge_q != '0) begin
      purge_q <= purge_q - QCNT_W'(1);
    end
  end

  // ------------------------------------------------------------
  // Receive, transmit and flush outputs
  // ------------------------------------------------------------
  always_comb begin
    rx_accept = rx_pkt & ~ctl_q[`PLK_BIT_ISO] & ctl_q[`PLK_BIT_IN_EN];
    rx_nack = rx_pkt & ~rx_accept;
    link_resp = rx_link_req;
    tx_link_req = tx_link_req_want;
    q_flush = ctl_q[`PLK_BIT_ISO] & ~iso_q;
    fab_ready = 1'b1;
    fab_drop = fab_valid & ctl_q[`PLK_BIT_ISO];
    tx_discard = 1'b0;
    tx_enable = ~ctl_q[`PLK_BIT_ISO] & ctl_q[`PLK_BIT_OUT_EN];
    unique case (policy)
      PLK_SEND: begin
        // Keep sending whatever the failure state
      end
      PLK_DROP_NACK: tx_discard = tx_nack & failed;
      PLK_HALT: begin
        if (out_fail) begin
          tx_enable = 1'b0;
        end
      end
      PLK_PURGE: tx_discard = out_fail & q_level_dec & (purge_q != '0);
    endcase
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (!reg_rd || port_pwr_down) begin
      reg_rdata <= '0;
    end else if (hit(reg_addr, `PLK_OFF_HDR)) begin
      reg_rdata <= `PLK_HDR_VAL;
    end else if (hit(reg_addr, PBASE)) begin
      reg_rdata <= {31'h0, edet_q};
    end else if (hit(reg_addr, PBASE + 16'h0008)) begin
      reg_rdata <= {26'h0, ack_q};
    end else if (hit(reg_addr, PBASE + 16'h0018)) begin
      reg_rdata <= {{(32-`PLK_ST_W){1'b0}}, stat_q};
    end else if (hit(reg_addr, PBASE + 16'h001C)) begin
      reg_rdata <= ctl_q;
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule : plk_port_ctl

//--- test/plk_port_ctl_assertions.sv
// Checker on the pins of the port lockout block.
// Assumes PORT_ID 0; bound by port names.
`timescale 1ns/1ps
`include "plk_defines.svh"
module plk_port_ctl_chk #(parameter int CNT_W = 8) (
  // Clock and resets
  input wire logic clk, rst, self_rst, port_rst,
  // Register port
  input wire logic [`PLK_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata, reg_rdata,
  input wire logic reg_wr, reg_rd, port_pwr_down,
  // Failure level
  input wire logic [CNT_W-1:0] error_rate_counter, error_rate_fail_level,
  input wire logic fail_level_en,
  // Link and fabric
  input wire logic rx_pkt, rx_accept, rx_nack, fab_valid, fab_drop, tx_enable, tx_discard,
  input wire logic q_flush
);
  logic [31:0] ctl_q;
  wire logic pen = reg_wr && !port_pwr_down && reg_addr == `PLK_OFF_CTL;
  wire logic iso = ctl_q[30];
  wire logic fail = fail_level_en && error_rate_counter >= error_rate_fail_level;
  // Shadow of the control word
  always_ff @(posedge clk) begin
    if (rst || self_rst || port_rst) begin
      ctl_q <= `PLK_CTL_RST;
    end else if (pen) begin
      ctl_q <= 32'h8000_0000 | reg_wdata & `PLK_CTL_WMASK;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || self_rst || port_rst);
  AST_OPEN: assert property (!iso && ctl_q[10] && rx_pkt |-> rx_accept)
    else $error("open port refused");
  AST_ISO: assert property (iso && rx_pkt |-> rx_nack && !rx_accept)
    else $error("isolated port accepted");
  AST_FAB: assert property (iso && fab_valid |-> fab_drop)
    else $error("fabric packet kept");
  AST_FLUSH: assert property ($rose(iso) |-> ##[0:1] q_flush)
    else $error("no flush");
  AST_PWR: assert property (reg_rd && port_pwr_down |=> reg_rdata == 32'h0)
    else $error("powered-down read");
  AST_CTL: assert property (
    reg_rd && !port_pwr_down && reg_addr == `PLK_OFF_CTL |=> reg_rdata == ctl_q)
    else $error("control read");
  AST_HALT: assert property (
    ctl_q[28] && !ctl_q[29] && fail && !pen |-> ##[1:2] !tx_enable)
    else $error("halt ignored");
  AST_SEND: assert property (
    !ctl_q[28] && !ctl_q[29] && !iso && ctl_q[9] |-> tx_enable)
    else $error("send stopped");
  cover property (iso && rx_nack);
  cover property (tx_discard);
  cover property (q_flush);
endmodule : plk_port_ctl_chk
bind plk_port_ctl plk_port_ctl_chk #(.CNT_W(CNT_W)) i_chk (.*);

//--- test/plk_link_model.sv
// Link partner model for the lockout block.
// Assumes the bench pulses send and refuse.
`timescale 1ns/1ps
module plk_link_model (
  // Bench side
  input wire logic clk, rst, send, refuse,
  // Port side
  input wire logic rx_nack,
  output logic rx_pkt, rx_link_req, tx_nack,
  output logic err_q
);
  assign rx_pkt = send;
  assign rx_link_req = send;
  assign tx_nack = refuse;
  always_ff @(posedge clk) begin
    if (rst) begin
      err_q <= 1'b0;
    end else if (rx_pkt && rx_nack) begin
      err_q <= 1'b1;
    end
  end
endmodule : plk_link_model

//--- test/tb_top.sv
// Bench for the port lockout block.
// Assumes PORT_ID 0, so the port group sits at 0x1040.
`timescale 1ns/1ps
module tb_top;
  logic clk = '0, rst = 1'b1, self_rst = '0, port_rst = '0, boot_load = '0;
  logic reg_wr = '0, reg_rd = '0, port_pwr_down = '0, fail_level_en = '0, bus_err = '0;
  logic tx_link_req_want = '0, ack_id_load = '0, fab_valid = '0, q_level_dec = '0;
  logic send = '0, refuse = '0;
  logic [31:0] boot_ctl = '0, reg_wdata = '0, reg_rdata, v, a;
  logic [15:0] reg_addr = '0;
  logic [7:0] error_rate_counter = '0, error_rate_fail_level = '0;
  logic [5:0] ack_id_in = '0;
  logic rx_pkt, rx_link_req, rx_accept, rx_nack, link_resp, tx_link_req, err_q;
  logic fab_ready, fab_drop, tx_nack, tx_enable, tx_discard, q_flush;
  int bad_count = 0, total_checks = 0, cyc = 0;
  plk_port_ctl i_plk_port_ctl (.*);
  plk_link_model i_plk_link_model (.*);
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      finish_test();
    end
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [15:0] ad, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task rc(input logic [15:0] ad, input logic [31:0] e, input string n);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(n, reg_rdata, e);
  endtask : rc
  task t_regs;
    rc(16'h105C, 32'h8000_0600, "ctl reset");
    rc(16'h1000, 32'h0000_0007, "header");
    rc(16'h1004, 32'h0000_0000, "unmapped");
    wr(16'h105C, 32'h0000_0000); // reserved bits zero
    rc(16'h105C, 32'h8000_0000, "kind");
    @(posedge clk);
    port_rst <= 1'b1;
    @(posedge clk);
    port_rst <= 1'b0;
    bus_err <= 1'b1;
    @(posedge clk);
    bus_err <= 1'b0;
    rc(16'h105C, 32'h8000_0600, "port reset");
    rc(16'h1040, 32'h0000_0001, "detect");
    $display("t_regs done");
  endtask : t_regs
  task t_iso;
    @(posedge clk);
    ack_id_in <= 6'h2A;
    ack_id_load <= 1'b1;
    @(posedge clk);
    ack_id_load <= 1'b0;
    rc(16'h1048, 32'h0000_002A, "ack load");
    wr(16'h105C, 32'h4000_0600);
    @(posedge clk);
    send <= 1'b1;
    fab_valid <= 1'b1;
    tx_link_req_want <= 1'b1;
    #1 chk("iso rx", {27'h0, tx_link_req, rx_nack, rx_accept, fab_drop, link_resp}, 32'h1B);
    @(posedge clk);
    send <= 1'b0;
    fab_valid <= 1'b0;
    tx_link_req_want <= 1'b0;
    #1 chk("partner err", {31'h0, err_q}, 32'h1);
    rc(16'h1058, 32'h0000_0003, "rx flags");
    rc(16'h1048, 32'h0000_002A, "ack kept");
    $display("t_iso done");
  endtask : t_iso
  task t_pwr;
    @(posedge clk);
    port_pwr_down <= 1'b1;
    rc(16'h105C, 32'h0000_0000, "pwr read");
    wr(16'h105C, 32'h0000_0600);
    @(posedge clk);
    port_pwr_down <= 1'b0;
    rc(16'h105C, 32'hC000_0600, "pwr write");
    $display("t_pwr done");
  endtask : t_pwr
  task t_fail;
    wr(16'h105C, 32'h1000_0600);
    wr(16'h1058, 32'h0000_000F);
    @(posedge clk);
    error_rate_counter <= 8'h05;
    error_rate_fail_level <= 8'h03;
    fail_level_en <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("halt", {31'h0, tx_enable}, 32'h0);
    wr(16'h105C, 32'h0000_0600);
    chk("send", {31'h0, tx_enable}, 32'h1);
    wr(16'h105C, 32'h2000_0600);
    @(posedge clk);
    refuse <= 1'b1;
    #1 chk("discard", {31'h0, tx_discard}, 32'h1);
    @(posedge clk);
    refuse <= 1'b0;
    error_rate_counter <= 8'h00;
    rc(16'h1058, 32'h0000_000C, "fail flags");
    @(posedge clk);
    refuse <= 1'b1;
    #1 chk("healed", {31'h0, tx_discard}, 32'h0);
    @(posedge clk);
    refuse <= 1'b0;
    $display("t_fail done");
  endtask : t_fail
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_iso();
    t_pwr();
    t_fail();
    finish_test();
  end
endmodule : tb_top
